// [rtl/cal_readout_pkg.sv]
package cal_readout_pkg;

  localparam int DQ_WIDTH   = 16;
  localparam int COL_BITS   = 4;
  localparam int READ_LAT   = 5;
  localparam int BURST_LEN  = 8;
  localparam int CLK_NS     = 10;
  localparam int PRECH_NS   = 15;
  // least time, so round up to whole cycles
  localparam int PRECH_CYC  = (PRECH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_SLACK   = 4;

  localparam logic [2:0] BA_MODE3     = 3'h3;
  localparam int         A_EN_POS     = 2;
  localparam int         A_LOC_LSB    = 0;
  localparam int         A_PRE_ALL    = 10;
  localparam logic       CAL_EN_RST   = 1'h0;
  localparam logic [1:0] CAL_LOC_RST  = 2'h0;
  localparam logic [1:0] LOC_PATTERN  = 2'h0;
  // beat k of a pattern burst drives bit k on every data line
  localparam logic [7:0] CAL_PATTERN  = 8'haa;

  // code is {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_MODE_WR = 4'h0,
    CMD_REF     = 4'h1,
    CMD_PRE     = 4'h2,
    CMD_ACT     = 4'h3,
    CMD_WRITE   = 4'h4,
    CMD_READ    = 4'h5,
    CMD_ZQ      = 4'h6,
    CMD_NOP     = 4'h7,
    CMD_DESEL   = 4'h8
  } cmd_t;

  typedef enum logic [2:0] {
    OP_READ    = 3'h0,
    OP_WRITE   = 3'h1,
    OP_CAL_ON  = 3'h2,
    OP_CAL_OFF = 3'h3,
    OP_DEV_RST = 3'h4
  } op_t;

  function automatic cmd_t cmd_decode(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    cmd_decode = CMD_DESEL;
    if (!cs_n) begin
      cmd_decode = cmd_t'({1'b0, ras_n, cas_n, we_n});
    end
  endfunction

endpackage

// [rtl/ddr_cmd_if.sv]
`timescale 1ns/1ns
interface ddr_cmd_if #(
  parameter int DQ_W = cal_readout_pkg::DQ_WIDTH
);
  logic            cs_n;
  logic            ras_n;
  logic            cas_n;
  logic            we_n;
  logic [2:0]      ba;
  logic [14:0]     addr;
  logic            reset_n;
  logic [DQ_W-1:0] dq_ctl;
  logic            dq_ctl_oe_n;
  logic [DQ_W-1:0] dq_dev;
  logic            dq_dev_oe_n;
  logic            dqs_dev;
  logic            dqs_dev_oe_n;
  // resolved data bus; an undriven bus reads as zero
  wire  [DQ_W-1:0] dq = !dq_dev_oe_n ? dq_dev : (!dq_ctl_oe_n ? dq_ctl : '0);

  modport dev (
    input  cs_n, ras_n, cas_n, we_n, ba, addr, reset_n, dq,
    output dq_dev, dq_dev_oe_n, dqs_dev, dqs_dev_oe_n
  );
  modport ctl (
    output cs_n, ras_n, cas_n, we_n, ba, addr, reset_n, dq_ctl, dq_ctl_oe_n,
    input  dq, dq_dev_oe_n, dqs_dev, dqs_dev_oe_n
  );
endinterface

// [rtl/cal_readout_dev.sv]
`timescale 1ns/1ns
module cal_readout_dev
  import cal_readout_pkg::*;
#(
  parameter int DQ_W   = DQ_WIDTH,
  parameter int COL_W  = COL_BITS,
  parameter int RD_LAT = READ_LAT
) (
  input  wire logic   I_REF_CLK,   // 100 MHz clock
  input  wire logic   I_SYS_RST,   // sync reset, active high
  input  wire logic   I_CLK_EN,    // freezes all state when low
  ddr_cmd_if.dev      BUS,         // command and data pins
  output logic        O_CAL_MODE,  // readout mode is on
  output logic [1:0]  O_CAL_LOC,   // selected readout location
  output logic        O_BAD_CMD    // pulse: command refused
);

  localparam int BEAT_W = $clog2(BURST_LEN);
  localparam int IDX_W  = 3 + COL_W;
  localparam int LAT_W  = 8;
  localparam logic [BEAT_W-1:0] BEAT_LAST = BEAT_W'(BURST_LEN - 1);

  typedef enum logic [2:0] {
    RD_IDLE  = 3'b001,
    RD_WAIT  = 3'b010,
    RD_BURST = 3'b100
  } rd_state_t;

  // small backing array; rows are not modelled
  logic [DQ_W-1:0] mem [0:(1<<IDX_W)-1];

  cmd_t              cmd;
  logic              mode_wr3;
  logic              allowed;
  logic              dev_rst;

  logic              cal_en_r;
  logic              cal_en_nxt;
  logic [1:0]        cal_loc_r;
  logic [1:0]        cal_loc_nxt;
  logic              bad_r;
  logic              bad_nxt;

  rd_state_t         st_r;
  rd_state_t         st_nxt;
  logic [LAT_W-1:0]  lat_r;
  logic [LAT_W-1:0]  lat_nxt;
  logic [BEAT_W-1:0] beat_r;
  logic [BEAT_W-1:0] beat_nxt;
  logic [2:0]        rbank_r;
  logic [2:0]        rbank_nxt;
  logic [COL_W-1:0]  rcol_r;
  logic [COL_W-1:0]  rcol_nxt;
  logic              rcal_r;
  logic              rcal_nxt;
  logic [1:0]        rloc_r;
  logic [1:0]        rloc_nxt;
  logic [DQ_W-1:0]   dq_r;
  logic [DQ_W-1:0]   dq_nxt;
  logic              dq_oe_n_r;
  logic              dq_oe_n_nxt;
  logic              dqs_r;
  logic              dqs_nxt;

  // bursts wrap inside an aligned group of eight columns
  function automatic logic [IDX_W-1:0] mem_idx(input logic [2:0] bank,
                                               input logic [COL_W-1:0] col,
                                               input logic [BEAT_W-1:0] beat);
    logic [BEAT_W-1:0] lo;
    lo = col[BEAT_W-1:0] + beat;
    mem_idx = {bank, col[COL_W-1:BEAT_W], lo};
  endfunction

  function automatic logic [DQ_W-1:0] beat_word(input logic cal,
                                                input logic [1:0] loc,
                                                input logic [BEAT_W-1:0] beat,
                                                input logic [DQ_W-1:0] arr);
    beat_word = '0;
    if (!cal) begin
      beat_word = arr;
    end else if (loc == LOC_PATTERN) begin
      beat_word = {DQ_W{CAL_PATTERN[beat]}};
    end
  endfunction

  // the pin is on the same clock as the controller logic, so no synchroniser
  assign dev_rst = I_SYS_RST || !BUS.reset_n;

  always_comb begin
    cmd      = cmd_decode(BUS.cs_n, BUS.ras_n, BUS.cas_n, BUS.we_n);
    mode_wr3 = (cmd == CMD_MODE_WR) && (BUS.ba == BA_MODE3);
    allowed  = !cal_en_r || (cmd == CMD_READ) || mode_wr3 ||
               (cmd == CMD_NOP) || (cmd == CMD_DESEL);
  end

  // mode register group
  always_comb begin
    cal_en_nxt  = cal_en_r;
    cal_loc_nxt = cal_loc_r;
    bad_nxt     = 1'b0;
    if (!allowed) begin
      // other commands in readout mode have no effect at all
      bad_nxt = 1'b1;
    end else if (mode_wr3) begin
      cal_en_nxt = BUS.addr[A_EN_POS];
      if (BUS.addr[A_EN_POS]) begin
        cal_loc_nxt = BUS.addr[A_LOC_LSB +: 2];
      end
    end
    if (cmd == CMD_READ && st_r != RD_IDLE) begin
      // a read landing on a running burst is dropped
      bad_nxt = 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (dev_rst) begin
      cal_en_r  <= CAL_EN_RST;
      cal_loc_r <= CAL_LOC_RST;
      bad_r     <= 1'b0;
    end else if (I_CLK_EN) begin
      cal_en_r  <= cal_en_nxt;
      cal_loc_r <= cal_loc_nxt;
      bad_r     <= bad_nxt;
    end
  end

  // read pipeline: one path for array and pattern reads
  always_comb begin
    st_nxt      = st_r;
    lat_nxt     = lat_r;
    beat_nxt    = beat_r;
    rbank_nxt   = rbank_r;
    rcol_nxt    = rcol_r;
    rcal_nxt    = rcal_r;
    rloc_nxt    = rloc_r;
    dq_nxt      = dq_r;
    dq_oe_n_nxt = 1'b1;
    dqs_nxt     = 1'b0;
    case (st_r)
      RD_IDLE: begin
        if (cmd == CMD_READ) begin
          st_nxt    = RD_WAIT;
          lat_nxt   = LAT_W'(RD_LAT - 1);
          rbank_nxt = BUS.ba;
          rcol_nxt  = BUS.addr[COL_W-1:0];
          rcal_nxt  = cal_en_r;
          rloc_nxt  = cal_loc_r;
        end
      end
      RD_WAIT: begin
        if (lat_r == '0) begin
          st_nxt      = RD_BURST;
          beat_nxt    = '0;
          dq_nxt      = beat_word(rcal_r, rloc_r, '0,
                                  mem[mem_idx(rbank_r, rcol_r, '0)]);
          dq_oe_n_nxt = 1'b0;
          dqs_nxt     = 1'b1;
        end else begin
          lat_nxt = lat_r - 1'b1;
        end
      end
      RD_BURST: begin
        if (beat_r == BEAT_LAST) begin
          st_nxt = RD_IDLE;
        end else begin
          beat_nxt    = beat_r + 1'b1;
          dq_nxt      = beat_word(rcal_r, rloc_r, beat_nxt,
                                  mem[mem_idx(rbank_r, rcol_r, beat_nxt)]);
          dq_oe_n_nxt = 1'b0;
          dqs_nxt     = ~beat_nxt[0];
        end
      end
      default: begin
        st_nxt = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (dev_rst) begin
      st_r      <= RD_IDLE;
      lat_r     <= '0;
      beat_r    <= '0;
      rbank_r   <= '0;
      rcol_r    <= '0;
      rcal_r    <= 1'b0;
      rloc_r    <= '0;
      dq_r      <= '0;
      dq_oe_n_r <= 1'b1;
      dqs_r     <= 1'b0;
    end else if (I_CLK_EN) begin
      st_r      <= st_nxt;
      lat_r     <= lat_nxt;
      beat_r    <= beat_nxt;
      rbank_r   <= rbank_nxt;
      rcol_r    <= rcol_nxt;
      rcal_r    <= rcal_nxt;
      rloc_r    <= rloc_nxt;
      dq_r      <= dq_nxt;
      dq_oe_n_r <= dq_oe_n_nxt;
      dqs_r     <= dqs_nxt;
    end
  end

  // single-beat write, data on the bus in the command cycle;
  // refused while readout mode is on so the array is untouched
  always_ff @(posedge I_REF_CLK) begin
    if (!dev_rst && I_CLK_EN && cmd == CMD_WRITE && !cal_en_r) begin
      mem[mem_idx(BUS.ba, BUS.addr[COL_W-1:0], '0)] <= BUS.dq;
    end
  end

  assign BUS.dq_dev       = dq_r;
  assign BUS.dq_dev_oe_n  = dq_oe_n_r;
  assign BUS.dqs_dev      = dqs_r;
  assign BUS.dqs_dev_oe_n = dq_oe_n_r;
  assign O_CAL_MODE       = cal_en_r;
  assign O_CAL_LOC        = cal_loc_r;
  assign O_BAD_CMD        = bad_r;

endmodule

// [rtl/cal_readout_ctl.sv]
`timescale 1ns/1ns
module cal_readout_ctl
  import cal_readout_pkg::*;
#(
  parameter int DQ_W   = DQ_WIDTH,
  parameter int RD_LAT = READ_LAT,
  parameter int PRECH  = PRECH_CYC
) (
  input  wire logic                    I_REF_CLK,    // 100 MHz clock
  input  wire logic                    I_SYS_RST,    // sync reset, active high
  input  wire logic                    I_CLK_EN,     // freezes all state when low
  input  wire logic                    I_REQ_VLD,    // request present
  input  wire op_t                     I_REQ_OP,     // request kind
  input  wire logic [2:0]              I_REQ_BANK,   // bank for read or write
  input  wire logic [14:0]             I_REQ_COL,    // column for read or write
  input  wire logic [1:0]              I_REQ_LOC,    // readout location for enable
  input  wire logic [DQ_W-1:0]         I_REQ_WDATA,  // write data
  ddr_cmd_if.ctl                       BUS,          // command and data pins
  output logic                         O_REQ_RDY,    // request taken when high
  output logic                         O_RD_VLD,     // pulse: burst complete
  output logic [BURST_LEN*DQ_W-1:0]    O_RD_DATA,    // burst, beat 0 lowest
  output logic                         O_CAL_MODE,   // readout mode requested
  output logic                         O_REJECT      // pulse: request refused
);

  localparam int CNT_W  = 8;
  localparam int BEAT_W = $clog2(BURST_LEN);
  localparam logic [CNT_W-1:0]  RD_LIMIT  = CNT_W'(RD_LAT + BURST_LEN + RD_SLACK);
  localparam logic [BEAT_W-1:0] BEAT_LAST = BEAT_W'(BURST_LEN - 1);

  typedef enum logic [2:0] {
    C_IDLE  = 3'b001,
    C_PRECH = 3'b010,
    C_READ  = 3'b100
  } ctl_state_t;

  ctl_state_t                  st_r, st_nxt;
  logic [CNT_W-1:0]            cnt_r, cnt_nxt;
  logic [BEAT_W-1:0]           beat_r, beat_nxt;
  cmd_t                        cmd_r, cmd_nxt;
  logic [2:0]                  ba_r, ba_nxt;
  logic [14:0]                 addr_r, addr_nxt;
  logic [DQ_W-1:0]             wd_r, wd_nxt;
  logic                        wd_oe_n_r, wd_oe_n_nxt;
  logic                        rstn_r, rstn_nxt;
  logic                        cal_r, cal_nxt;
  logic [1:0]                  loc_r, loc_nxt;
  logic                        rdy_r, rdy_nxt;
  logic                        rej_r, rej_nxt;
  logic                        vld_r, vld_nxt;
  logic [BURST_LEN*DQ_W-1:0]   data_r, data_nxt;

  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    beat_nxt    = beat_r;
    cmd_nxt     = CMD_NOP;
    ba_nxt      = '0;
    addr_nxt    = '0;
    wd_nxt      = wd_r;
    wd_oe_n_nxt = 1'b1;
    rstn_nxt    = 1'b1;
    cal_nxt     = cal_r;
    loc_nxt     = loc_r;
    rej_nxt     = 1'b0;
    vld_nxt     = 1'b0;
    data_nxt    = data_r;
    case (st_r)
      C_IDLE: begin
        if (I_REQ_VLD && rdy_r) begin
          case (I_REQ_OP)
            OP_READ: begin
              cmd_nxt  = CMD_READ;
              ba_nxt   = I_REQ_BANK;
              addr_nxt = I_REQ_COL;
              st_nxt   = C_READ;
              cnt_nxt  = '0;
              beat_nxt = '0;
            end
            OP_WRITE: begin
              if (cal_r) begin
                rej_nxt = 1'b1;
              end else begin
                cmd_nxt     = CMD_WRITE;
                ba_nxt      = I_REQ_BANK;
                addr_nxt    = I_REQ_COL;
                wd_nxt      = I_REQ_WDATA;
                wd_oe_n_nxt = 1'b0;
              end
            end
            OP_CAL_ON: begin
              if (cal_r) begin
                rej_nxt = 1'b1;
              end else begin
                // close every bank, then wait out the precharge period
                cmd_nxt             = CMD_PRE;
                addr_nxt[A_PRE_ALL] = 1'b1;
                loc_nxt             = I_REQ_LOC;
                st_nxt              = C_PRECH;
                cnt_nxt             = CNT_W'(PRECH - 1);
              end
            end
            OP_CAL_OFF: begin
              cmd_nxt = CMD_MODE_WR;
              ba_nxt  = BA_MODE3;
              cal_nxt = 1'b0;
            end
            OP_DEV_RST: begin
              rstn_nxt = 1'b0;
              cal_nxt  = 1'b0;
            end
            default: begin
              rej_nxt = 1'b1;
            end
          endcase
        end
      end
      C_PRECH: begin
        if (cnt_r == '0) begin
          cmd_nxt                   = CMD_MODE_WR;
          ba_nxt                    = BA_MODE3;
          addr_nxt[A_EN_POS]        = 1'b1;
          addr_nxt[A_LOC_LSB +: 2]  = loc_r;
          cal_nxt                   = 1'b1;
          st_nxt                    = C_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      C_READ: begin
        cnt_nxt = cnt_r + 1'b1;
        if (!BUS.dq_dev_oe_n) begin
          data_nxt[beat_r*DQ_W +: DQ_W] = BUS.dq;
          beat_nxt = beat_r + 1'b1;
          if (beat_r == BEAT_LAST) begin
            vld_nxt = 1'b1;
            st_nxt  = C_IDLE;
          end
        end else if (cnt_r == RD_LIMIT) begin
          // device reset mid-burst leaves the read unanswered
          rej_nxt = 1'b1;
          st_nxt  = C_IDLE;
        end
      end
      default: begin
        st_nxt = C_IDLE;
      end
    endcase
    rdy_nxt = (st_nxt == C_IDLE);
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      st_r      <= C_IDLE;
      cnt_r     <= '0;
      beat_r    <= '0;
      cmd_r     <= CMD_NOP;
      ba_r      <= '0;
      addr_r    <= '0;
      wd_r      <= '0;
      wd_oe_n_r <= 1'b1;
      rstn_r    <= 1'b0;
      cal_r     <= CAL_EN_RST;
      loc_r     <= CAL_LOC_RST;
      rdy_r     <= 1'b0;
      rej_r     <= 1'b0;
      vld_r     <= 1'b0;
      data_r    <= '0;
    end else if (I_CLK_EN) begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      beat_r    <= beat_nxt;
      cmd_r     <= cmd_nxt;
      ba_r      <= ba_nxt;
      addr_r    <= addr_nxt;
      wd_r      <= wd_nxt;
      wd_oe_n_r <= wd_oe_n_nxt;
      rstn_r    <= rstn_nxt;
      cal_r     <= cal_nxt;
      loc_r     <= loc_nxt;
      rdy_r     <= rdy_nxt;
      rej_r     <= rej_nxt;
      vld_r     <= vld_nxt;
      data_r    <= data_nxt;
    end
  end

  assign BUS.cs_n        = cmd_r[3];
  assign BUS.ras_n       = cmd_r[2];
  assign BUS.cas_n       = cmd_r[1];
  assign BUS.we_n        = cmd_r[0];
  assign BUS.ba          = ba_r;
  assign BUS.addr        = addr_r;
  assign BUS.reset_n     = rstn_r;
  assign BUS.dq_ctl      = wd_r;
  assign BUS.dq_ctl_oe_n = wd_oe_n_r;
  assign O_REQ_RDY       = rdy_r;
  assign O_RD_VLD        = vld_r;
  assign O_RD_DATA       = data_r;
  assign O_CAL_MODE      = cal_r;
  assign O_REJECT        = rej_r;

endmodule

// [test/cal_readout_props.sv]
`timescale 1ns/1ns
module cal_readout_props
  import cal_readout_pkg::*;
#(
  parameter int RD_LAT = READ_LAT,
  parameter int PRECH  = PRECH_CYC
) (
  input wire logic        I_REF_CLK,    // shared clock
  input wire logic        I_SYS_RST,    // sync reset, active high
  input wire logic        cs_n,         // command strobes
  input wire logic        ras_n,        // command strobes
  input wire logic        cas_n,        // command strobes
  input wire logic        we_n,         // command strobes
  input wire logic [2:0]  ba,           // bank select
  input wire logic [14:0] addr,         // address
  input wire logic        reset_n,      // device reset, low active
  input wire logic [15:0] dq,           // resolved data bus
  input wire logic        dq_dev_oe_n,  // device drives data when low
  input wire logic        dqs_dev,      // device strobe
  input wire logic        dqs_dev_oe_n  // device drives strobe when low
);
  localparam int LAT_LO = RD_LAT;
  localparam int LAT_HI = RD_LAT + 1;
  logic [3:0] cmd;
  logic       pre_all;
  logic       mode_r;
  logic       mode_nxt;
  logic [1:0] loc_r;
  logic [1:0] loc_nxt;

  assign cmd     = {cs_n, ras_n, cas_n, we_n};
  assign pre_all = (cmd == CMD_PRE) && addr[A_PRE_ALL];

  // mirror of the mode bits so beat checks know which pattern to expect
  always_comb begin
    mode_nxt = mode_r;
    loc_nxt  = loc_r;
    if (cmd == CMD_MODE_WR && ba == BA_MODE3) begin
      mode_nxt = addr[A_EN_POS];
      if (addr[A_EN_POS]) begin
        loc_nxt = addr[1:0];
      end
    end
  end
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST || !reset_n) begin
      mode_r <= 1'b0;
      loc_r  <= 2'h0;
    end else begin
      mode_r <= mode_nxt;
      loc_r  <= loc_nxt;
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST || !reset_n);

  sequence s_burst;
    !dq_dev_oe_n [*8] ##1 dq_dev_oe_n;
  endsequence
  sequence s_pattern;
    dq == 16'h0000 ##1 dq == 16'hffff ##1 dq == 16'h0000 ##1 dq == 16'hffff;
  endsequence
  sequence s_strobe;
    dqs_dev && !dqs_dev_oe_n ##1 !dqs_dev ##1 dqs_dev ##1 !dqs_dev;
  endsequence

  chk_mode_wr_bank: assert property (cmd == CMD_MODE_WR |-> ba == BA_MODE3)
    else $error("mode write not aimed at third register");
  chk_reserved_zero: assert property (cmd == CMD_MODE_WR |-> addr[14:3] == 12'h0)
    else $error("reserved address bits set in mode write");
  chk_precharge_first: assert property (cmd == CMD_MODE_WR && addr[A_EN_POS] |-> $past(pre_all, PRECH))
    else $error("readout enabled without precharge");
  chk_read_only_mode: assert property (mode_r && !cs_n && cmd != CMD_NOP
      |-> cmd == CMD_READ || (cmd == CMD_MODE_WR && ba == BA_MODE3))
    else $error("forbidden command in readout mode");
  chk_read_latency: assert property (cmd == CMD_READ |-> ##[LAT_LO:LAT_HI] $fell(dq_dev_oe_n))
    else $error("read burst late");
  chk_burst_length: assert property ($fell(dq_dev_oe_n) |-> s_burst)
    else $error("burst not eight beats");
  chk_strobe_beats: assert property ($fell(dq_dev_oe_n) |-> s_strobe)
    else $error("strobe does not toggle per beat");
  chk_pattern_beats: assert property ($fell(dq_dev_oe_n) && mode_r && loc_r == LOC_PATTERN |-> s_pattern)
    else $error("pattern beats wrong");
  chk_other_loc_zero: assert property ($fell(dq_dev_oe_n) && mode_r && loc_r != LOC_PATTERN
      |-> (dq == 16'h0000) [*8])
    else $error("unused location not zero");
  chk_reset_abort: assert property (disable iff (I_SYS_RST) !reset_n |=> dq_dev_oe_n && dqs_dev_oe_n)
    else $error("reset did not stop the burst");
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import cal_readout_pkg::*;
  logic         clk;
  logic         rst;
  logic         vld;
  op_t          op;
  logic [2:0]   bank;
  logic [14:0]  col;
  logic [1:0]   loc;
  logic [15:0]  wd;
  logic         rdy;
  logic         rd_vld;
  logic [127:0] rd_data;
  logic         ctl_mode;
  logic         rej;
  logic         dev_mode;
  logic [1:0]   dev_loc;
  logic         bad;
  logic         dev2_mode;
  logic [1:0]   dev2_loc;
  logic         bad2;
  int           n_fail = 0;
  int           check_count = 0;
  int           cycles = 0;
  localparam logic [127:0] PAT = {4{16'hffff, 16'h0000}};
  localparam logic [127:0] LOW = {112'h0, 16'hffff};

  ddr_cmd_if bus ();
  ddr_cmd_if bus2 ();

  cal_readout_ctl u_cal_readout_ctl (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(1'b1), .I_REQ_VLD(vld),
    .I_REQ_OP(op), .I_REQ_BANK(bank), .I_REQ_COL(col), .I_REQ_LOC(loc), .I_REQ_WDATA(wd), .O_REQ_RDY(rdy),
    .O_RD_VLD(rd_vld), .O_RD_DATA(rd_data), .O_CAL_MODE(ctl_mode), .O_REJECT(rej), .BUS(bus));
  cal_readout_dev u_cal_readout_dev (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(1'b1), .BUS(bus),
    .O_CAL_MODE(dev_mode), .O_CAL_LOC(dev_loc), .O_BAD_CMD(bad));
  // second device faces a bench driver that breaks the command rules on purpose
  cal_readout_dev u_cal_readout_dev_b (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(1'b1), .BUS(bus2),
    .O_CAL_MODE(dev2_mode), .O_CAL_LOC(dev2_loc), .O_BAD_CMD(bad2));
  cal_readout_props u_cal_readout_props (.I_REF_CLK(clk), .I_SYS_RST(rst), .cs_n(bus.cs_n), .ras_n(bus.ras_n),
    .cas_n(bus.cas_n), .we_n(bus.we_n), .ba(bus.ba), .addr(bus.addr), .reset_n(bus.reset_n), .dq(bus.dq),
    .dq_dev_oe_n(bus.dq_dev_oe_n), .dqs_dev(bus.dqs_dev), .dqs_dev_oe_n(bus.dqs_dev_oe_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t flag got %b want %b", $time, got, exp);
    end
  endtask

  task automatic chk_data(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t data got %h want %h", $time, got, exp);
    end
  endtask

  task automatic req(input op_t o, input logic [1:0] l, input logic [15:0] w);
    int n;
    n = 0;
    @(negedge clk);
    op = o;
    loc = l;
    wd = w;
    vld = 1'b1;
    while (rdy !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    vld = 1'b0;
  endtask

  // latency counted from the taking edge to the completion pulse
  task automatic rd(input logic [127:0] exp, input logic [127:0] mask);
    int lat;
    req(OP_READ, 2'h0, 16'h0);
    lat = 0;
    while (rd_vld !== 1'b1 && lat < 100) begin
      @(negedge clk);
      lat++;
    end
    chk_bit(lat == READ_LAT + 9, 1'b1);
    chk_data(rd_data & mask, exp);
  endtask

  // the refusal pulse stands only in the cycle after the taking edge
  task automatic refuse(input op_t o);
    req(o, 2'h0, 16'h0);
    chk_bit(rej, 1'b1);
  endtask

  // a free edge first, so back-to-back calls never drive a pin twice at once
  task automatic drv2(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
    @(negedge clk);
    {bus2.cs_n, bus2.ras_n, bus2.cas_n, bus2.we_n} = c;
    bus2.ba = b;
    bus2.addr = a;
    @(negedge clk);
    {bus2.cs_n, bus2.ras_n, bus2.cas_n, bus2.we_n} = CMD_NOP;
    bus2.addr = 15'h0;
  endtask

  always @(negedge clk) begin
    if (!rst && {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} == CMD_MODE_WR) begin
      chk_bit(bus.ba === BA_MODE3 && bus.addr[14:3] === 12'h0, 1'b1);
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_fail++;
      end_of_test;
    end
  end

  initial begin
    rst = 1'b1;
    vld = 1'b0;
    op = OP_READ;
    bank = 3'h2;
    col = 15'h0003;
    loc = 2'h0;
    wd = 16'h0;
    {bus2.cs_n, bus2.ras_n, bus2.cas_n, bus2.we_n} = CMD_NOP;
    bus2.ba = 3'h0;
    bus2.addr = 15'h0;
    bus2.reset_n = 1'b1;
    bus2.dq_ctl = 16'h0;
    bus2.dq_ctl_oe_n = 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    req(OP_WRITE, 2'h0, 16'h1234);
    rd({112'h0, 16'h1234}, LOW);
    req(OP_CAL_ON, LOC_PATTERN, 16'h0);
    repeat (4) @(negedge clk);
    chk_bit(dev_mode, 1'b1);
    chk_bit(ctl_mode, 1'b1);
    rd(PAT, '1);
    refuse(OP_WRITE);
    refuse(OP_CAL_ON);
    chk_bit(dev_mode, 1'b1);
    chk_bit(bad, 1'b0);
    req(OP_CAL_OFF, 2'h2, 16'h0);
    repeat (2) @(negedge clk);
    chk_bit(dev_mode, 1'b0);
    chk_bit(dev_loc === LOC_PATTERN, 1'b1);
    rd({112'h0, 16'h1234}, LOW);
    req(OP_CAL_ON, 2'h1, 16'h0);
    repeat (4) @(negedge clk);
    chk_bit(dev_loc === 2'h1, 1'b1);
    rd(128'h0, '1);
    req(OP_DEV_RST, 2'h0, 16'h0);
    repeat (3) @(negedge clk);
    chk_bit(dev_mode, 1'b0);
    chk_bit(ctl_mode, 1'b0);
    drv2(CMD_PRE, 3'h0, 15'h0400);
    @(negedge clk);
    drv2(CMD_MODE_WR, BA_MODE3, 15'h0004);
    chk_bit(dev2_mode, 1'b1);
    // refresh, precharge, activate, write and ZQ are each refused without effect
    for (int i = 1; i < 7; i++) begin
      if (i != 5) begin
        drv2(i[3:0], 3'h0, 15'h0);
        chk_bit(bad2, 1'b1);
        chk_bit(dev2_mode, 1'b1);
      end
    end
    drv2(CMD_READ, 3'h0, 15'h0);
    chk_bit(bad2, 1'b0);
    // beat 1 of the burst is on the pins now
    repeat (READ_LAT + 1) @(negedge clk);
    chk_bit(bus2.dq_dev_oe_n, 1'b0);
    chk_bit(bus2.dq === {16{CAL_PATTERN[1]}}, 1'b1);
    bus2.reset_n = 1'b0;
    @(negedge clk);
    bus2.reset_n = 1'b1;
    chk_bit(dev2_mode, 1'b0);
    chk_bit(bus2.dq_dev_oe_n, 1'b1);
    drv2(CMD_MODE_WR, BA_MODE3, 15'h0005);
    drv2(CMD_MODE_WR, BA_MODE3, 15'h0002);
    chk_bit(dev2_mode, 1'b0);
    chk_bit(dev2_loc === 2'h1, 1'b1);
    end_of_test;
  end
endmodule
